// ===== core/mtp_host_ctrl.sv
// host controller driving the memory command interface from Avalon-MM
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "mtp_params.svh"

// Contract
// - host masks reserved status bits; the code masks STATUS only, RDATA keeps the raw word read after 70h
// - 70h then read returns status
// - release strobes before each status reread
// - erase is 20h then D0h in block
// - after buffer setup, read extended status
// - count, address/data pairs, then confirm
// - word program is 40h then address/data
// - set lock is 60h then confirm; the code follows 60h with 01h
// - clear locks invalid while sequencer busy
// - host repeats aborted clear locks
// - FFh returns to array read mode
module mtp_host_ctrl (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // memory pins
  output logic [21:0]      mem_addr,
  input  wire logic [15:0] mem_dq_in,
  output logic [15:0]      mem_dq_out,
  output logic             mem_dq_oe,
  output logic             mem_ce_n,
  output logic             mem_oe_n,
  output logic             mem_we_n
);

  mtp_pkg::mtp_state_e state_ff;
  mtp_pkg::mtp_state_e nxt_state;
  mtp_pkg::mtp_op_e    op_ff;
  mtp_pkg::mtp_op_e    wr_op;
  logic        ack_ff;
  logic [31:0] rd_mux;
  logic [3:0]  cnt_ff;
  logic [3:0]  idx_ff;
  logic [21:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rdata_ff;
  logic [15:0] rdcfg_ff;
  logic [7:0]  sr_ff;
  logic        done_ff;
  logic        refused_ff;
  logic        fail_seen_ff;
  logic        buf_seen_ff;
  logic        seq_err_ff;
  logic [1:0]  retry_ff;
  logic        issued_ff;
  logic        start_ff;
  logic [15:0] buf_mem [16];
  logic        wr_acc;
  logic        cmd_go;
  logic        accept;
  logic        finish;
  logic        cyc_read;
  logic [21:0] cyc_addr;
  logic [15:0] cyc_data;
  logic        cyc_done;
  logic [15:0] cyc_rdata;
  logic        ev_ready;
  logic        ev_buf_free;
  logic [7:0]  ev_sr;
  logic        ev_seq_err;
  logic [7:0]  code1;
  logic [7:0]  code2;
  logic        retry_go;

  // one wait state on every access keeps read data registered
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign wr_acc = avs_write & ack_ff;
  assign cmd_go = wr_acc && avs_address == `MTP_REG_CMD;
  assign wr_op  = mtp_pkg::mtp_op_e'(avs_writedata[3:0]);
  // a new command only when the device sequencer is known idle
  assign accept = cmd_go && state_ff == mtp_pkg::S_IDLE
                  && avs_writedata[3:0] <= 4'h9
                  && !(wr_op == mtp_pkg::MTP_OP_BUF_PROG
                       && fail_seen_ff);
  assign finish = state_ff != mtp_pkg::S_IDLE
                  && nxt_state == mtp_pkg::S_IDLE;
  // an aborted clear-locks leaves lock bits undefined; repeat it
  assign retry_go = op_ff == mtp_pkg::MTP_OP_LOCK_CLEAR
                    && ev_sr[`MTP_SR_VOLT] && retry_ff != 2'h0;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff       <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
      if (avs_read && !ack_ff) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    if (avs_address[`MTP_REG_BUF_BIT]) begin
      rd_mux[15:0] = buf_mem[avs_address[3:0]];
    end else begin
      case (avs_address)
        `MTP_REG_CMD:   rd_mux = {20'h0, cnt_ff, 4'h0, op_ff};
        `MTP_REG_ADDR:  rd_mux = {10'h0, addr_ff};
        `MTP_REG_WDATA: rd_mux = {16'h0, wdata_ff};
        `MTP_REG_RDATA: rd_mux = {16'h0, rdata_ff};
        `MTP_REG_RDCFG: rd_mux = {16'h0, rdcfg_ff};
        `MTP_REG_STATUS: begin
          rd_mux[`MTP_STAT_BUSY]    = state_ff != mtp_pkg::S_IDLE;
          rd_mux[`MTP_STAT_DONE]    = done_ff;
          rd_mux[`MTP_STAT_REFUSED] = refused_ff;
          rd_mux[`MTP_STAT_FAIL]    = fail_seen_ff;
          rd_mux[`MTP_STAT_SR_LSB +: 8] = sr_ff;
          rd_mux[`MTP_STAT_BUF]     = buf_seen_ff;
          rd_mux[`MTP_STAT_SEQ]     = seq_err_ff;
        end
        default: rd_mux = 32'h0;
      endcase
    end
  end

  // software-written parameters of the next operation
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_ff  <= 22'h0;
      wdata_ff <= 16'h0;
      rdcfg_ff <= `MTP_RDCFG_RESET;
    end else if (wr_acc && !avs_address[`MTP_REG_BUF_BIT]) begin
      case (avs_address)
        `MTP_REG_ADDR:  addr_ff  <= avs_writedata[21:0];
        `MTP_REG_WDATA: wdata_ff <= avs_writedata[15:0];
        `MTP_REG_RDCFG: begin
          rdcfg_ff <= 16'h0;
          rdcfg_ff[`MTP_RDCFG_PAGE] <= avs_writedata[`MTP_RDCFG_PAGE];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (wr_acc && avs_address[`MTP_REG_BUF_BIT]) begin
      buf_mem[avs_address[3:0]] <= avs_writedata[15:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_ff    <= mtp_pkg::MTP_OP_READ_ARRAY;
      cnt_ff   <= 4'h0;
      retry_ff <= 2'h0;
    end else if (accept) begin
      op_ff    <= wr_op;
      cnt_ff   <= avs_writedata[11:8];
      retry_ff <= `MTP_LOCK_RETRIES;
    end else if (state_ff == mtp_pkg::S_POLL && cyc_done && ev_ready
                 && retry_go) begin
      retry_ff <= retry_ff - 2'h1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      mtp_pkg::S_IDLE: if (accept) begin
        nxt_state = (wr_op == mtp_pkg::MTP_OP_READ_WORD) ?
                    mtp_pkg::S_READ : mtp_pkg::S_CMD1;
      end
      mtp_pkg::S_CMD1: if (cyc_done) begin
        case (op_ff)
          mtp_pkg::MTP_OP_READ_ARRAY: nxt_state = mtp_pkg::S_IDLE;
          mtp_pkg::MTP_OP_CLEAR_STAT: nxt_state = mtp_pkg::S_IDLE;
          mtp_pkg::MTP_OP_READ_STAT:  nxt_state = mtp_pkg::S_READ;
          mtp_pkg::MTP_OP_BUF_PROG:   nxt_state = mtp_pkg::S_EXT;
          default:                    nxt_state = mtp_pkg::S_CONF;
        endcase
      end
      // no free buffer: issue the setup again and recheck
      mtp_pkg::S_EXT: if (cyc_done) begin
        nxt_state = ev_buf_free ? mtp_pkg::S_CNT : mtp_pkg::S_CMD1;
      end
      mtp_pkg::S_CNT: if (cyc_done) begin
        nxt_state = mtp_pkg::S_DATA;
      end
      mtp_pkg::S_DATA: if (cyc_done && idx_ff == cnt_ff) begin
        nxt_state = mtp_pkg::S_CONF;
      end
      // the device reports status without a 70h after the S_CONF cycle of any operation
      mtp_pkg::S_CONF: if (cyc_done) begin
        nxt_state = mtp_pkg::S_POLL;
      end
      mtp_pkg::S_POLL: if (cyc_done && ev_ready) begin
        nxt_state = retry_go ? mtp_pkg::S_CLR : mtp_pkg::S_IDLE;
      end
      mtp_pkg::S_CLR: if (cyc_done) begin
        nxt_state = mtp_pkg::S_CMD1;
      end
      mtp_pkg::S_READ: if (cyc_done) begin
        nxt_state = mtp_pkg::S_IDLE;
      end
      default: nxt_state = mtp_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= mtp_pkg::S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idx_ff <= 4'h0;
    end else if (state_ff == mtp_pkg::S_CNT) begin
      idx_ff <= 4'h0;
    end else if (state_ff == mtp_pkg::S_DATA && cyc_done) begin
      idx_ff <= idx_ff + 4'h1;
    end
  end

  // each state runs one pin cycle at a time; S_POLL and S_DATA run further ones while they stay
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      issued_ff <= 1'b0;
      start_ff  <= 1'b0;
    end else begin
      start_ff <= state_ff != mtp_pkg::S_IDLE && !issued_ff && !cyc_done;
      if (cyc_done) begin
        issued_ff <= 1'b0;
      end else if (state_ff != mtp_pkg::S_IDLE) begin
        issued_ff <= 1'b1;
      end
    end
  end

  always_comb begin
    code1 = `MTP_CMD_LOCK_SETUP;
    code2 = `MTP_CMD_CONFIRM;
    case (op_ff)
      mtp_pkg::MTP_OP_READ_ARRAY: code1 = `MTP_CMD_READ_ARRAY;
      mtp_pkg::MTP_OP_READ_STAT:  code1 = `MTP_CMD_READ_STAT;
      mtp_pkg::MTP_OP_CLEAR_STAT: code1 = `MTP_CMD_CLEAR_STAT;
      mtp_pkg::MTP_OP_ERASE:      code1 = `MTP_CMD_ERASE;
      mtp_pkg::MTP_OP_WORD_PROG:  code1 = `MTP_CMD_WORD_PROG;
      mtp_pkg::MTP_OP_BUF_PROG:   code1 = `MTP_CMD_BUF_SETUP;
      mtp_pkg::MTP_OP_LOCK_SET:   code2 = `MTP_CMD_LOCK_SET;
      mtp_pkg::MTP_OP_RDCFG:      code2 = `MTP_CMD_RDCFG_CONF;
      default: ;
    endcase
  end

  always_comb begin
    cyc_read = 1'b0;
    cyc_addr = addr_ff;
    cyc_data = 16'h0;
    case (state_ff)
      mtp_pkg::S_CMD1, mtp_pkg::S_CONF: begin
        cyc_data = {8'h00,
                    (state_ff == mtp_pkg::S_CMD1) ? code1 : code2};
        if (state_ff == mtp_pkg::S_CONF
            && op_ff == mtp_pkg::MTP_OP_WORD_PROG) begin
          cyc_data = wdata_ff;
        end
        if (op_ff == mtp_pkg::MTP_OP_RDCFG) begin
          cyc_addr = {6'h00, rdcfg_ff};
        end
      end
      mtp_pkg::S_EXT, mtp_pkg::S_POLL, mtp_pkg::S_READ: cyc_read = 1'b1;
      mtp_pkg::S_CNT:  cyc_data = {12'h000, cnt_ff};
      mtp_pkg::S_DATA: begin
        cyc_addr = addr_ff + {18'h0, idx_ff};
        cyc_data = buf_mem[idx_ff];
      end
      mtp_pkg::S_CLR: cyc_data = {8'h00, `MTP_CMD_CLEAR_STAT};
      default: ;
    endcase
  end

  // results of the finished cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff    <= 16'h0;
      sr_ff       <= 8'h00;
      seq_err_ff  <= 1'b0;
      buf_seen_ff <= 1'b0;
    end else if (cyc_done) begin
      if (state_ff == mtp_pkg::S_READ) begin
        rdata_ff <= cyc_rdata;
      end
      if (state_ff == mtp_pkg::S_EXT) begin
        buf_seen_ff <= ev_buf_free;
      end
      if ((state_ff == mtp_pkg::S_POLL && ev_ready)
          || (state_ff == mtp_pkg::S_READ
              && op_ff == mtp_pkg::MTP_OP_READ_STAT)) begin
        sr_ff      <= ev_sr;
        seq_err_ff <= ev_seq_err;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fail_seen_ff <= 1'b0;
    end else if (state_ff == mtp_pkg::S_POLL && cyc_done && ev_ready
                 && (ev_sr[`MTP_SR_PROG] || ev_sr[`MTP_SR_ERASE])) begin
      fail_seen_ff <= 1'b1;
    end else if (cyc_done && (state_ff == mtp_pkg::S_CLR
                 || (state_ff == mtp_pkg::S_CMD1
                     && op_ff == mtp_pkg::MTP_OP_CLEAR_STAT))) begin
      fail_seen_ff <= 1'b0;
    end
  end

  // sticky flags: a new event wins over a software clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_ff    <= 1'b0;
      refused_ff <= 1'b0;
    end else begin
      if (finish) begin
        done_ff <= 1'b1;
      end else if (wr_acc && avs_address == `MTP_REG_STATUS
                   && avs_writedata[`MTP_STAT_DONE]) begin
        done_ff <= 1'b0;
      end
      if (cmd_go && !accept) begin
        refused_ff <= 1'b1;
      end else if (wr_acc && avs_address == `MTP_REG_STATUS
                   && avs_writedata[`MTP_STAT_REFUSED]) begin
        refused_ff <= 1'b0;
      end
    end
  end

  mtp_bus_cycle u_cycle (
    .clk        (clk),
    .reset_n    (reset_n),
    .start      (start_ff),
    .is_read    (cyc_read),
    .addr       (cyc_addr),
    .wdata      (cyc_data),
    .done       (cyc_done),
    .rdata      (cyc_rdata),
    .mem_addr   (mem_addr),
    .mem_dq_in  (mem_dq_in),
    .mem_dq_out (mem_dq_out),
    .mem_dq_oe  (mem_dq_oe),
    .mem_ce_n   (mem_ce_n),
    .mem_oe_n   (mem_oe_n),
    .mem_we_n   (mem_we_n)
  );

  mtp_status_eval u_eval (
    .raw              (cyc_rdata),
    .ready            (ev_ready),
    .buffer_free_flag (ev_buf_free),
    .sr               (ev_sr),
    .seq_err          (ev_seq_err)
  );

  a_buf_refuse: assert property (
    @(posedge clk) disable iff (!reset_n)
    (cmd_go && wr_op == mtp_pkg::MTP_OP_BUF_PROG && fail_seen_ff)
      |=> refused_ff && op_ff == $past(op_ff))
    else $error("buffer setup taken with failure flag set");

  a_poll_again: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_ff == mtp_pkg::S_POLL && cyc_done && !ev_ready)
      |=> (state_ff == mtp_pkg::S_POLL && !start_ff) ##1 start_ff)
    else $error("busy status not polled again");

  a_rdcfg_reserved: assert property (
    @(posedge clk) disable iff (!reset_n)
    rdcfg_ff[14:0] == 15'h0)
    else $error("reserved read configuration bits set");

  a_sr_masked: assert property (
    @(posedge clk) disable iff (!reset_n)
    sr_ff[6] == 1'b0 && sr_ff[2] == 1'b0 && sr_ff[0] == 1'b0
    && (sr_ff[`MTP_SR_READY] || sr_ff == 8'h00))
    else $error("reserved or undriven status bits kept");

  a_erase_seq: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_ff == mtp_pkg::S_CMD1 && op_ff == mtp_pkg::MTP_OP_ERASE
     && cyc_done) |=> state_ff == mtp_pkg::S_CONF ##2
      cyc_data == {8'h00, `MTP_CMD_CONFIRM})
    else $error("erase not followed by confirm");

  a_status_cmd: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_ff == mtp_pkg::S_CMD1 && op_ff == mtp_pkg::MTP_OP_READ_STAT
     && cyc_done) |=> state_ff == mtp_pkg::S_READ && cyc_read)
    else $error("status command not followed by read");

  a_clear_fail: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_ff == mtp_pkg::S_CMD1 && op_ff == mtp_pkg::MTP_OP_CLEAR_STAT
     && cyc_done) |=> !fail_seen_ff && state_ff == mtp_pkg::S_IDLE)
    else $error("clear status did not clear failure flag");

  a_wait_once: assert property (
    @(posedge clk) disable iff (!reset_n)
    ((avs_read || avs_write) && !ack_ff) |-> avs_waitrequest ##1 ack_ff)
    else $error("waitrequest not released after one cycle");

endmodule

// ===== shared/mtp_params.svh
// timing counts, command codes, bit positions and register offsets
`ifndef MTP_PARAMS_SVH
`define MTP_PARAMS_SVH

`define MTP_CLK_NS        25
`define MTP_WP_NS         70
`define MTP_ACC_NS        100
`define MTP_REC_NS        30
`define MTP_WP_CYC  ((`MTP_WP_NS + `MTP_CLK_NS - 1) / `MTP_CLK_NS)
`define MTP_ACC_CYC ((`MTP_ACC_NS + `MTP_CLK_NS - 1) / `MTP_CLK_NS)
`define MTP_REC_CYC ((`MTP_REC_NS + `MTP_CLK_NS - 1) / `MTP_CLK_NS)

`define MTP_CMD_READ_ARRAY 8'hff
`define MTP_CMD_READ_STAT  8'h70
`define MTP_CMD_CLEAR_STAT 8'h50
`define MTP_CMD_ERASE      8'h20
`define MTP_CMD_CONFIRM    8'hd0
`define MTP_CMD_WORD_PROG  8'h40
`define MTP_CMD_BUF_SETUP  8'he8
`define MTP_CMD_LOCK_SETUP 8'h60
`define MTP_CMD_LOCK_SET   8'h01
`define MTP_CMD_RDCFG_CONF 8'h03

`define MTP_SR_READY       7
`define MTP_SR_ERASE       5
`define MTP_SR_PROG        4
`define MTP_SR_VOLT        3
`define MTP_SR_LOCK        1
`define MTP_EXT_BUF        7
`define MTP_RDCFG_PAGE     15

`define MTP_REG_CMD        5'h00
`define MTP_REG_ADDR       5'h01
`define MTP_REG_WDATA      5'h02
`define MTP_REG_RDATA      5'h03
`define MTP_REG_STATUS     5'h04
`define MTP_REG_RDCFG      5'h05
`define MTP_REG_BUF_BIT    4

`define MTP_STAT_BUSY      0
`define MTP_STAT_DONE      1
`define MTP_STAT_REFUSED   2
`define MTP_STAT_FAIL      3
`define MTP_STAT_SR_LSB    8
`define MTP_STAT_BUF       16
`define MTP_STAT_SEQ       17

`define MTP_LOCK_RETRIES   2'h2
`define MTP_RDCFG_RESET    16'h0000

`endif

// ===== shared/mtp_pkg.sv
// types shared by the memory host controller
package mtp_pkg;

  typedef enum logic [3:0] {
    MTP_OP_READ_ARRAY = 4'h0,
    MTP_OP_READ_STAT  = 4'h1,
    MTP_OP_CLEAR_STAT = 4'h2,
    MTP_OP_READ_WORD  = 4'h3,
    MTP_OP_ERASE      = 4'h4,
    MTP_OP_WORD_PROG  = 4'h5,
    MTP_OP_BUF_PROG   = 4'h6,
    MTP_OP_LOCK_SET   = 4'h7,
    MTP_OP_LOCK_CLEAR = 4'h8,
    MTP_OP_RDCFG      = 4'h9
  } mtp_op_e;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_CMD1 = 9'h002,
    S_EXT  = 9'h004,
    S_CNT  = 9'h008,
    S_DATA = 9'h010,
    S_CONF = 9'h020,
    S_POLL = 9'h040,
    S_CLR  = 9'h080,
    S_READ = 9'h100
  } mtp_state_e;

  typedef enum logic [2:0] {
    CY_IDLE   = 3'h1,
    CY_STROBE = 3'h2,
    CY_RECOV  = 3'h4
  } mtp_cyc_e;

endpackage

// ===== core/mtp_status_eval.sv
// decodes a status or extended status word read from the memory
`timescale 1ns/1ps
`include "mtp_params.svh"

module mtp_status_eval (
  // raw word from the data pins
  input  wire logic [15:0] raw,
  // decoded view
  output logic             ready,
  output logic             buffer_free_flag,
  output logic [7:0]       sr,
  output logic             seq_err
);

  assign ready            = raw[`MTP_SR_READY];
  assign buffer_free_flag = raw[`MTP_EXT_BUF];
  // lower bits float while busy, so only bit 7 is trusted then
  always_comb begin
    sr = 8'h00;
    sr[`MTP_SR_READY] = raw[`MTP_SR_READY];
    if (raw[`MTP_SR_READY]) begin
      sr[`MTP_SR_ERASE] = raw[`MTP_SR_ERASE];
      sr[`MTP_SR_PROG]  = raw[`MTP_SR_PROG];
      sr[`MTP_SR_VOLT]  = raw[`MTP_SR_VOLT];
      sr[`MTP_SR_LOCK]  = raw[`MTP_SR_LOCK];
    end
  end
  assign seq_err = sr[`MTP_SR_ERASE] & sr[`MTP_SR_PROG];

endmodule

// ===== core/mtp_bus_cycle.sv
// one asynchronous read or write cycle on the memory pins
`timescale 1ns/1ps
`include "mtp_params.svh"

module mtp_bus_cycle (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // cycle request
  input  wire logic        start,
  input  wire logic        is_read,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  // memory pins
  output logic [21:0]      mem_addr,
  input  wire logic [15:0] mem_dq_in,
  output logic [15:0]      mem_dq_out,
  output logic             mem_dq_oe,
  output logic             mem_ce_n,
  output logic             mem_oe_n,
  output logic             mem_we_n
);

  mtp_pkg::mtp_cyc_e st_ff;
  logic [2:0]        cnt_ff;
  logic              rd_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff  <= mtp_pkg::CY_IDLE;
      cnt_ff <= 3'h0;
      rd_ff  <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_ff)
        mtp_pkg::CY_IDLE: if (start) begin
          st_ff  <= mtp_pkg::CY_STROBE;
          rd_ff  <= is_read;
          cnt_ff <= is_read ? 3'(`MTP_ACC_CYC - 1) : 3'(`MTP_WP_CYC - 1);
        end
        mtp_pkg::CY_STROBE: if (cnt_ff == 3'h0) begin
          st_ff  <= mtp_pkg::CY_RECOV;
          cnt_ff <= 3'(`MTP_REC_CYC - 1);
        end else begin
          cnt_ff <= cnt_ff - 3'h1;
        end
        mtp_pkg::CY_RECOV: if (cnt_ff == 3'h0) begin
          st_ff <= mtp_pkg::CY_IDLE;
          done  <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 3'h1;
        end
        default: st_ff <= mtp_pkg::CY_IDLE;
      endcase
    end
  end

  // address and data are held through recovery so the device latches
  // them on the rising strobe with margin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr   <= 22'h0;
      mem_dq_out <= 16'h0;
      mem_dq_oe  <= 1'b0;
      mem_ce_n   <= 1'b1;
      mem_oe_n   <= 1'b1;
      mem_we_n   <= 1'b1;
      rdata      <= 16'h0;
    end else if (st_ff == mtp_pkg::CY_IDLE && start) begin
      mem_addr   <= addr;
      mem_dq_out <= wdata;
      mem_dq_oe  <= !is_read;
      mem_ce_n   <= 1'b0;
      mem_oe_n   <= !is_read;
      mem_we_n   <= is_read;
    end else if (st_ff == mtp_pkg::CY_STROBE && cnt_ff == 3'h0) begin
      mem_ce_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_we_n <= 1'b1;
      if (rd_ff) begin
        rdata <= mem_dq_in;
      end
    end else if (st_ff == mtp_pkg::CY_RECOV && cnt_ff == 3'h0) begin
      mem_dq_oe <= 1'b0;
    end
  end

  a_we_width: assert property (
    @(posedge clk) disable iff (!reset_n)
    $fell(mem_we_n) |-> !mem_we_n [*3] ##1 mem_we_n)
    else $error("write strobe width wrong");

  a_strobe_excl: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!mem_we_n || !mem_oe_n) |-> !mem_ce_n && (mem_we_n || mem_oe_n))
    else $error("strobes overlap or chip not selected");

  a_dq_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!mem_we_n && !$fell(mem_we_n)) |->
      mem_dq_oe && $stable(mem_dq_out) && $stable(mem_addr))
    else $error("write data moved during strobe");

  a_read_gap: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(mem_oe_n) |-> (mem_oe_n && mem_ce_n) [*2])
    else $error("read strobe not released before reread");

endmodule

// ===== bench/mtp_dev_model.sv
// behavioural model of the memory device behind the pins
`timescale 1ns/1ps
module mtp_dev_model (
  // pins and supply condition
  input  wire logic        clk,
  input  wire logic        enable_supply_low,
  input  wire logic [21:0] mem_addr,
  input  wire logic [15:0] mem_dq_out,
  input  wire logic        mem_dq_oe,
  input  wire logic        mem_ce_n,
  input  wire logic        mem_oe_n,
  input  wire logic        mem_we_n,
  output logic [15:0]      mem_dq_in
);
  logic [15:0] arr [64];
  logic [15:0] q = 16'h0;
  logic [7:0]  sr = 8'h80;
  logic [7:0]  pend = 8'h0;
  logic [4:0]  cnt = 5'h0;
  logic [3:0]  busy = 4'h0;
  logic [1:0]  mode = 2'h0;
  logic        lk = 1'b0;
  logic        wq = 1'b0;
  logic        rq = 1'b0;
  logic [7:0]  p = 8'h0;
  // protection words lie outside the modelled array, never reached
  // a released bus shows the inverse of the last word, never a held value
  assign mem_dq_in = (!mem_oe_n && !mem_ce_n) ? q : ~q;
  task automatic pgm();
    if (enable_supply_low) sr |= 8'h18;
    else if (lk) sr |= 8'h12;
    else arr[mem_addr[5:0]] &= mem_dq_out;
  endtask
  task automatic go();
    pend = 8'h0;
    busy = 4'hf;
    mode = 2'h1;
  endtask
  // sampled mid-cycle, clear of the controller's own edge
  always @(negedge clk) begin
    if (busy != 4'h0) busy--;
    if (wq && !(!mem_we_n && !mem_ce_n)) begin
      p = pend;
      // an undriven data bus at the latching edge counts as a bad sequence
      if (!mem_dq_oe) sr |= 8'h30;
      case (pend)
        8'h40: pgm();
        8'he8: cnt = mem_dq_out[4:0] + 5'h1;
        8'hb0: if (cnt != 5'h0 && !sr[4]) pgm();
        8'h20: if (mem_dq_out[7:0] == 8'hd0)
            arr = '{default: 16'hffff};
          else sr |= 8'h30;
        8'h60: if (enable_supply_low) sr |= 8'h18;
          else if (mem_dq_out[7:0] == 8'h01) lk = 1'b1;
          else if (mem_dq_out[7:0] == 8'hd0) lk = 1'b0;
          else if (mem_dq_out[7:0] != 8'h03) sr |= 8'h30;
        default: case (mem_dq_out[7:0])
          8'h70: mode = 2'h1;
          8'hff: mode = 2'h0;
          8'h50: sr = 8'h80;
          8'he8: mode = 2'h2;
          default: pend = mem_dq_out[7:0];
        endcase
      endcase
      // follow-up keyed on the code pending before this write, so a
      // first-cycle setup code is not launched at once
      if (p == 8'he8) pend = 8'hb0;
      else if (p == 8'hb0 && cnt != 5'h0) cnt--;
      else if (p != 8'h0) go();
      if (mode == 2'h2 && pend == 8'h0 && sr[5:4] == 2'h0)
        pend = 8'he8;
    end
    if (!mem_oe_n && !mem_ce_n && !rq) begin
      if (mode == 2'h0) q = arr[mem_addr[5:0]];
      else if (busy != 4'h0) q = {9'h0, ~q[6:0]};
      else if (mode == 2'h1) q = {8'h0, sr};
      else q = {8'h0, ~(sr[5] | sr[4]), ~q[6:0]};
    end
    wq = !mem_we_n && !mem_ce_n;
    rq = !mem_oe_n && !mem_ce_n;
  end
endmodule

// ===== bench/mtp_host_ctrl_tb_top.sv
// self-checking bench for the memory host controller
`timescale 1ns/1ps
module mtp_host_ctrl_tb_top;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        enable_supply_low = 1'b0;
  logic [4:0]  avs_address = 5'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [21:0] mem_addr;
  logic [15:0] mem_dq_in;
  logic [15:0] mem_dq_out;
  logic        mem_dq_oe;
  logic        mem_ce_n;
  logic        mem_oe_n;
  logic        mem_we_n;
  logic [31:0] v;
  logic [15:0] got;
  int          num_errors = 0;
  int          checks = 0;
  // op, address, write data, expected status byte or read word
  logic [15:0] tbl [15][4] = '{
    '{16'h4, 16'h5, 16'h0, 16'h80}, '{16'h3, 16'h5, 16'h0, 16'h80},
    '{16'h0, 16'h0, 16'h0, 16'h80}, '{16'h3, 16'h5, 16'h0, 16'hffff},
    '{16'h5, 16'h5, 16'h1234, 16'h80}, '{16'h0, 16'h0, 16'h0, 16'h80},
    '{16'h3, 16'h5, 16'h0, 16'h1234}, '{16'h1, 16'h0, 16'h0, 16'h80},
    '{16'h106, 16'h8, 16'h0, 16'h80}, '{16'h0, 16'h0, 16'h0, 16'h80},
    '{16'h3, 16'h9, 16'h0, 16'h5555}, '{16'h9, 16'h0, 16'h0, 16'h80},
    '{16'h7, 16'h6, 16'h0, 16'h80}, '{16'h5, 16'h6, 16'h0, 16'h92},
    '{16'h8, 16'h0, 16'h0, 16'h92}};
  mtp_host_ctrl dut_u (.*);
  mtp_dev_model dev_u (.*);
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic results();
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      results();
    end
  endtask
  task automatic op(input logic [15:0] c, input logic [15:0] a,
                    input logic [15:0] d);
    bus(1'b1, 5'h1, a);
    bus(1'b1, 5'h2, d);
    bus(1'b1, 5'h0, c);
    repeat (500) begin
      bus(1'b0, 5'h4, 16'h0);
      if (v[0] === 1'b0) break;
    end
    if (v[0] !== 1'b0) begin
      num_errors++;
      results();
    end
    if (c == 16'h3) bus(1'b0, 5'h3, 16'h0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    bus(1'b0, 5'h4, 16'h0);
    chk(v[15:0], 16'h0);
    bus(1'b1, 5'h5, 16'hffff);
    bus(1'b0, 5'h5, 16'h0);
    chk(v[15:0], 16'h8000);
    bus(1'b1, 5'h10, 16'haaaa);
    bus(1'b1, 5'h11, 16'h5555);
    for (int i = 0; i < 15; i++) begin
      op(tbl[i][0], tbl[i][1], tbl[i][2]);
      got = (tbl[i][0] == 16'h3) ? v[15:0] : {8'h0, v[15:8]};
      chk(got, tbl[i][3]);
    end
    op(16'h2, 16'h0, 16'h0);
    op(16'h5, 16'h6, 16'h0);
    chk({8'h0, v[15:8]}, 16'h80);
    enable_supply_low <= 1'b1;
    op(16'h5, 16'h7, 16'h0);
    chk({8'h0, v[15:8]}, 16'h98);
    op(16'h106, 16'h8, 16'h0);
    chk({15'h0, v[2]}, 16'h1);
    op(16'h7, 16'h7, 16'h0);
    op(16'h8, 16'h0, 16'h0);
    chk({8'h0, v[15:8]}, 16'h98);
    op(16'h2, 16'h0, 16'h0);
    enable_supply_low <= 1'b0;
    op(16'h5, 16'h7, 16'h0);
    chk({8'h0, v[15:8]}, 16'h80);
    results();
  end
endmodule
